//--- common/pio_pkg.sv
// Constants, register map and pin layout of the programmable I/O port bank
package pio_pkg;
  // ==================== Bank geometry ====================
  localparam int NPORT       = 11;
  localparam int PW          = 8;
  localparam int NPIN        = NPORT * PW;
  localparam int NBUS_PORT   = 6;
  localparam int NBUS_PIN    = NBUS_PORT * PW;
  localparam int PU_GRP      = 4;
  localparam int NPU_GRP     = NPIN / PU_GRP;
  localparam int NPU_REG     = 3;
  localparam int PORT_ONE    = 1;
  localparam int IN_ONLY_IDX = 8 * PW + 5;
  localparam int PINS_LARGE  = 87;
  localparam int PINS_SMALL  = 70;

  // ==================== Register map ====================
  localparam logic [7:0] A_DATA_BASE = 8'h00;
  localparam logic [7:0] A_DIR_BASE  = 8'h10;
  localparam logic [7:0] A_PU_BASE   = 8'h20;
  localparam logic [7:0] A_CTRL      = 8'h24;
  localparam int         CTRL_RSEL   = 0;

  // ==================== Reset values ====================
  localparam logic [NPIN-1:0]    RST_LATCH = '0;
  localparam logic [NPIN-1:0]    RST_DIR   = '0;
  localparam logic [NPU_GRP-1:0] RST_PU    = '0;
  localparam logic [7:0]         RST_CTRL  = 8'h00;

  // ==================== Pin masks ====================
  localparam logic [NPIN-1:0] IN_ONLY_MASK = NPIN'(1) << IN_ONLY_IDX;
  // Pins kept internal in the smaller package
  localparam logic [NPIN-1:0] SMALL_NC_MASK = 88'h0002003C0000F00000FF00;
endpackage

//--- common/pio_port_if.sv
// Per-port signal bundle between the bank control and one port driver
`timescale 1ns/1ps
`default_nettype none
interface pio_port_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] pu_en;
  logic [7:0] periph_oe;
  logic [7:0] periph_out;
  logic [7:0] bus_oe;
  logic [7:0] bus_out;
  logic [7:0] pad_in;
  logic [7:0] no_pad;
  logic [7:0] in_only;
  logic       bus_sel;
  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [7:0] drv_pu;
  logic [7:0] lvl;

  modport ctl (output latch, dir, pu_en, periph_oe, periph_out, bus_oe, bus_out,
               pad_in, no_pad, in_only, bus_sel,
               input  drv_out, drv_oe, drv_pu, lvl);
  modport drv (input  latch, dir, pu_en, periph_oe, periph_out, bus_oe, bus_out,
               pad_in, no_pad, in_only, bus_sel,
               output drv_out, drv_oe, drv_pu, lvl);
endinterface
`default_nettype wire

//--- rtl/pio_port_drv.sv
// Pad drive, pull-up and sensed level for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module pio_port_drv (
  pio_port_if.drv p
);
  import pio_pkg::*;

  always_comb begin
    for (int b = 0; b < PW; b++) begin
      if (p.bus_sel) begin
        p.drv_oe[b]  = p.bus_oe[b];
        p.drv_out[b] = p.bus_out[b];
        p.drv_pu[b]  = 1'b0;
      end else begin
        p.drv_oe[b]  = p.dir[b] | p.periph_oe[b];
        p.drv_out[b] = p.periph_oe[b] ? p.periph_out[b] : p.latch[b];
        p.drv_pu[b]  = p.pu_en[b] & ~p.dir[b] & ~p.periph_oe[b];
      end
      // Input-only and padless pins never reach a pad
      if (p.in_only[b] || p.no_pad[b]) begin
        p.drv_oe[b] = 1'b0;
        p.drv_pu[b] = 1'b0;
      end
      p.lvl[b] = p.no_pad[b] ? p.latch[b] : p.pad_in[b];
    end
  end
endmodule
`default_nettype wire

//--- rtl/pio_strap.sv
// Captures the package-variant strap once after reset release
`timescale 1ns/1ps
`default_nettype none
module pio_strap (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic strap_in,
  output var  logic strap_r
);
  logic done_r;
  logic done_nxt;
  logic strap_nxt;

  always_comb begin
    done_nxt  = 1'b1;
    strap_nxt = done_r ? strap_r : strap_in;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r  <= 1'b0;
      strap_r <= 1'b0;
    end else begin
      done_r  <= done_nxt;
      strap_r <= strap_nxt;
    end
  end
endmodule
`default_nettype wire

//--- rtl/pio_bank.sv
// Programmable I/O port bank: registers, pin drive and read paths
//
// Summary of operation
// - Each pin except the input-only pin has its own direction bit selecting input or output.
// - Port register holds an output latch; reads return sensed pin state, or the latch for padless pins.
// - Input-only pin has no direction bit, no pull-up, never drives.
// - One pull-up control bit covers a block of four adjacent pins.
// - Enabled pull-up acts only while the pin's direction is input.
// - In external-bus modes ports zero to five carry the bus; pull-ups ignored.
// - Peripheral output (not the converter) drives the pin regardless of direction.
// - Larger package exposes 87 programmable pins across ports zero to ten.
// - Smaller package keeps some bits internal, leaving 70 pins at pads.
// - Read-select clear: port one reads pin when input, latch when output.
// - Read-select set: port one always reads the output latch.
`timescale 1ns/1ps
`default_nettype none
module pio_bank (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output var  logic [7:0]                   reg_rdata,
  input  wire logic                         bus_mode,
  input  wire logic [pio_pkg::NBUS_PIN-1:0] bus_oe,
  input  wire logic [pio_pkg::NBUS_PIN-1:0] bus_out,
  input  wire logic [pio_pkg::NPIN-1:0]     periph_oe,
  input  wire logic [pio_pkg::NPIN-1:0]     periph_out,
  input  wire logic                         pkg_small,
  input  wire logic [pio_pkg::NPIN-1:0]     pad_in,
  output var  logic [pio_pkg::NPIN-1:0]     pad_out,
  output var  logic [pio_pkg::NPIN-1:0]     pad_oe,
  output var  logic [pio_pkg::NPIN-1:0]     pad_pu
);
  import pio_pkg::*;

  // ==================== Helpers ====================
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base,
                                  input int n);
    in_win = (a >= base) && ({24'h000000, a} < ({24'h000000, base} + 32'(n)));
  endfunction

  function automatic int win_idx(input logic [7:0] a, input logic [7:0] base);
    win_idx = int'(a - base);
  endfunction

  // ==================== Register state ====================
  logic [NPIN-1:0]    latch_r;
  logic [NPIN-1:0]    latch_nxt;
  logic [NPIN-1:0]    dir_r;
  logic [NPIN-1:0]    dir_nxt;
  logic [NPU_GRP-1:0] pu_r;
  logic [NPU_GRP-1:0] pu_nxt;
  logic [7:0]         ctrl_r;
  logic [7:0]         ctrl_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;

  logic [NPIN-1:0]    pad_out_r;
  logic [NPIN-1:0]    pad_out_nxt;
  logic [NPIN-1:0]    pad_oe_r;
  logic [NPIN-1:0]    pad_oe_nxt;
  logic [NPIN-1:0]    pad_pu_r;
  logic [NPIN-1:0]    pad_pu_nxt;

  logic               small_r;
  logic [NPIN-1:0]    no_pad;
  logic [NPIN-1:0]    pu_pin;
  logic [NPIN-1:0]    lvl;

  assign reg_rdata = rdata_r;
  assign pad_out   = pad_out_r;
  assign pad_oe    = pad_oe_r;
  assign pad_pu    = pad_pu_r;

  // ==================== Package variant ====================
  pio_strap u_strap (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .strap_in (pkg_small),
    .strap_r  (small_r)
  );

  assign no_pad = small_r ? SMALL_NC_MASK : '0;

  // ==================== Pull-up group fan-out ====================
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pu_pin[i] = pu_r[i / PU_GRP];
    end
  end

  // ==================== Per-port drivers ====================
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    pio_port_if prt ();

    assign prt.latch      = latch_r[g*PW +: PW];
    assign prt.dir        = dir_r[g*PW +: PW];
    assign prt.pu_en      = pu_pin[g*PW +: PW];
    assign prt.periph_oe  = periph_oe[g*PW +: PW];
    assign prt.periph_out = periph_out[g*PW +: PW];
    assign prt.pad_in     = pad_in[g*PW +: PW];
    assign prt.no_pad     = no_pad[g*PW +: PW];
    assign prt.in_only    = IN_ONLY_MASK[g*PW +: PW];
    if (g < NBUS_PORT) begin : g_bus
      assign prt.bus_sel = bus_mode;
      assign prt.bus_oe  = bus_oe[g*PW +: PW];
      assign prt.bus_out = bus_out[g*PW +: PW];
    end else begin : g_nobus
      assign prt.bus_sel = 1'b0;
      assign prt.bus_oe  = 8'h00;
      assign prt.bus_out = 8'h00;
    end

    pio_port_drv u_drv (
      .p (prt.drv)
    );

    assign pad_out_nxt[g*PW +: PW] = prt.drv_out;
    assign pad_oe_nxt[g*PW +: PW]  = prt.drv_oe;
    assign pad_pu_nxt[g*PW +: PW]  = prt.drv_pu;
    assign lvl[g*PW +: PW]         = prt.lvl;
  end

  // ==================== Register writes ====================
  always_comb begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    pu_nxt    = pu_r;
    ctrl_nxt  = ctrl_r;
    if (reg_wr) begin
      if (in_win(reg_addr, A_DATA_BASE, NPORT)) begin
        latch_nxt[win_idx(reg_addr, A_DATA_BASE)*PW +: PW] = reg_wdata;
      end
      if (in_win(reg_addr, A_DIR_BASE, NPORT)) begin
        dir_nxt[win_idx(reg_addr, A_DIR_BASE)*PW +: PW] = reg_wdata;
      end
      if (in_win(reg_addr, A_PU_BASE, NPU_REG)) begin
        for (int b = 0; b < PW; b++) begin
          if (win_idx(reg_addr, A_PU_BASE)*PW + b < NPU_GRP) begin
            pu_nxt[win_idx(reg_addr, A_PU_BASE)*PW + b] = reg_wdata[b];
          end
        end
      end
      if (reg_addr == A_CTRL) begin
        ctrl_nxt = {7'h00, reg_wdata[CTRL_RSEL]};
      end
    end
    dir_nxt = dir_nxt & ~IN_ONLY_MASK;
  end

  // ==================== Register reads ====================
  always_comb begin
    logic [7:0] v;
    v         = 8'h00;
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (in_win(reg_addr, A_DATA_BASE, NPORT)) begin
        v = lvl[win_idx(reg_addr, A_DATA_BASE)*PW +: PW];
        if (win_idx(reg_addr, A_DATA_BASE) == PORT_ONE) begin
          if (ctrl_r[CTRL_RSEL]) begin
            v = latch_r[PORT_ONE*PW +: PW];
          end else begin
            v = (latch_r[PORT_ONE*PW +: PW] & dir_r[PORT_ONE*PW +: PW]) |
                (lvl[PORT_ONE*PW +: PW] & ~dir_r[PORT_ONE*PW +: PW]);
          end
        end
        rdata_nxt = v;
      end else if (in_win(reg_addr, A_DIR_BASE, NPORT)) begin
        rdata_nxt = dir_r[win_idx(reg_addr, A_DIR_BASE)*PW +: PW];
      end else if (in_win(reg_addr, A_PU_BASE, NPU_REG)) begin
        for (int b = 0; b < PW; b++) begin
          if (win_idx(reg_addr, A_PU_BASE)*PW + b < NPU_GRP) begin
            rdata_nxt[b] = pu_r[win_idx(reg_addr, A_PU_BASE)*PW + b];
          end
        end
      end else if (reg_addr == A_CTRL) begin
        rdata_nxt = ctrl_r;
      end
    end
  end

  // ==================== State registers ====================
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r   <= RST_LATCH;
      dir_r     <= RST_DIR;
      pu_r      <= RST_PU;
      ctrl_r    <= RST_CTRL;
      rdata_r   <= 8'h00;
      pad_out_r <= '0;
      pad_oe_r  <= '0;
      pad_pu_r  <= '0;
    end else begin
      latch_r   <= latch_nxt;
      dir_r     <= dir_nxt;
      pu_r      <= pu_nxt;
      ctrl_r    <= ctrl_nxt;
      rdata_r   <= rdata_nxt;
      pad_out_r <= pad_out_nxt;
      pad_oe_r  <= pad_oe_nxt;
      pad_pu_r  <= pad_pu_nxt;
    end
  end

  // ==================== Checks ====================
  dir_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr && reg_addr == A_DIR_BASE + 8'h03 |=> dir_r[31:24] == $past(reg_wdata))
    else $error("direction write not stored");

  dir_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    dir_r[88-1] && !periph_oe[88-1] |=> pad_oe_r[88-1] && pad_out_r[88-1] == $past(latch_r[88-1]))
    else $error("output pin not driven from latch");

  latch_store_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr && reg_addr == A_DATA_BASE + 8'h02 |=> latch_r[23:16] == $past(reg_wdata))
    else $error("port latch lost written value");

  in_only_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !pad_oe_r[IN_ONLY_IDX] && !pad_pu_r[IN_ONLY_IDX] && !dir_r[IN_ONLY_IDX])
    else $error("input-only pin driven or pulled up");

  pu_group_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    pu_r[12] && dir_r[51:48] == 4'h0 && periph_oe[51:48] == 4'h0
    |=> pad_pu_r[51:48] == 4'hF)
    else $error("pull-up group not applied to all four pins");

  pu_input_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 (pad_pu_r & $past(dir_r)) == '0)
    else $error("pull-up on an output pin");

  bus_pu_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    bus_mode |=> pad_pu_r[NBUS_PIN-1:0] == '0 && pad_oe_r[7:0] == $past(bus_oe[7:0]))
    else $error("bus ports not handed to the external bus");

  periph_drv_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    periph_oe[80] && !dir_r[80] |=> pad_oe_r[80] && pad_out_r[80] == $past(periph_out[80]))
    else $error("peripheral output not forced onto pin");

  pad_count_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $countones(~no_pad & ~IN_ONLY_MASK) == (small_r ? PINS_SMALL : PINS_LARGE))
    else $error("exposed pin count wrong");

  rd_mixed_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && reg_addr == A_DATA_BASE + 8'h01 && !ctrl_r[CTRL_RSEL] |=>
    reg_rdata == (($past(latch_r[15:8]) & $past(dir_r[15:8])) |
                  ($past(lvl[15:8]) & ~$past(dir_r[15:8]))))
    else $error("port one read ignores direction");

  rd_latch_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && reg_addr == A_DATA_BASE + 8'h01 && ctrl_r[CTRL_RSEL] |=>
    reg_rdata == $past(latch_r[15:8]))
    else $error("port one read not from latch");

  reset_state_a: assert property (
    @(posedge sys_clk)
    !rst_b |-> dir_r == '0 && pu_r == '0 && pad_oe_r == '0 && pad_pu_r == '0)
    else $error("pins not input after reset");

  rd_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

  in_only_rd_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd && reg_addr == A_DIR_BASE + 8'h08 |=> reg_rdata[5] == 1'b0)
    else $error("input-only pin shows a direction bit");

  bus_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    bus_mode && !small_r |=> pad_oe_r[NBUS_PIN-1:0] == $past(bus_oe) &&
    pad_out_r[NBUS_PIN-1:0] == $past(bus_out))
    else $error("bus ports not following the external bus");

  drive_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !bus_mode |=> pad_oe_r ==
    (($past(dir_r) | $past(periph_oe)) & ~$past(no_pad) & ~IN_ONLY_MASK))
    else $error("pad enable not from direction and peripheral");

  no_pad_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    small_r |=> ((pad_oe_r | pad_pu_r) & SMALL_NC_MASK) == '0)
    else $error("padless pin driven or pulled up");

  rsel_store_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr && reg_addr == A_CTRL |=> ctrl_r[CTRL_RSEL] == $past(reg_wdata[CTRL_RSEL]))
    else $error("read select not stored");

  rsel_only_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ctrl_r[7:1] == 7'h00)
    else $error("unused control bits set");
endmodule
`default_nettype wire

//--- bench/pio_pads_model.sv
// External devices and wiring seen at the port bank pads
`timescale 1ns/1ps
`default_nettype none
module pio_pads_model (
  input  wire logic                     sys_clk,
  input  wire logic [pio_pkg::NPIN-1:0] pad_out,
  input  wire logic [pio_pkg::NPIN-1:0] pad_oe,
  input  wire logic [pio_pkg::NPIN-1:0] pad_pu,
  input  wire logic [pio_pkg::NPIN-1:0] ext_oe,
  input  wire logic [pio_pkg::NPIN-1:0] ext_val,
  output var  logic [pio_pkg::NPIN-1:0] pad_in
);
  import pio_pkg::*;
  logic [NPIN-1:0] flt_r = '0;
  // Undriven, unpulled line wanders every cycle
  always @(posedge sys_clk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i] && ext_oe[i]) pad_in[i] = 1'bx;
      else if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else pad_in[i] = pad_pu[i] | flt_r[i];
    end
  end
endmodule
`default_nettype wire

//--- bench/test_programmable_io_ports.sv
// Self-checking bench of the programmable I/O port bank
`timescale 1ns/1ps
`default_nettype none
module test_programmable_io_ports;
  import pio_pkg::*;
  localparam int DB = A_DIR_BASE;
  localparam int PB = A_PU_BASE;
  logic                sys_clk, rst_b, reg_wr, reg_rd, bus_mode, pkg_small;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata, rd_exp;
  logic [NBUS_PIN-1:0] bus_oe, bus_out;
  logic [NPIN-1:0]     periph_oe, periph_out, pad_in, pad_out, pad_oe, pad_pu;
  logic [NPIN-1:0]     ext_en, ext_val, ext_oe, m_lat, m_dir, e_oe, e_out, e_pu;
  logic [NPU_GRP-1:0]  m_pu;
  logic                m_rsel, m_small, rd_pend, chk_en;
  logic [7:0]          bad [5] = '{8'h0B, 8'h1B, 8'h23, 8'h25, 8'hFF};
  logic [31:0]         seed;
  int                  failures, n_compared, rel_cnt, i, g, a;

  pio_bank dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_mode(bus_mode),
    .bus_oe(bus_oe), .bus_out(bus_out), .periph_oe(periph_oe), .periph_out(periph_out),
    .pkg_small(pkg_small), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu));
  pio_pads_model far (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in));
  // Outside drivers release any pin the bank drives
  assign ext_oe = ext_en & ~e_oe;

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==================== Helpers ====================
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [NPIN-1:0] r88();
    return NPIN'({rnd(), rnd(), rnd()});
  endfunction
  function automatic logic lvl(int p);
    return e_oe[p] ? e_out[p] : (ext_oe[p] ? ext_val[p] : e_pu[p]);
  endfunction
  function automatic logic [7:0] exp_rd(int ad);
    logic [7:0] v;
    int         p;
    v = 8'h00;
    if (ad < NPORT) begin
      for (int b = 0; b < 8; b++) begin
        p = ad * 8 + b;
        v[b] = ((ad == PORT_ONE && (m_rsel || m_dir[p])) || (m_small && SMALL_NC_MASK[p])) ?
               m_lat[p] : lvl(p);
      end
    end else if (ad >= DB && ad < DB + NPORT) v = m_dir[(ad - DB) * 8 +: 8];
    else if (ad >= PB && ad < PB + NPU_REG) begin
      for (int b = 0; b < 8; b++) if ((ad - PB) * 8 + b < NPU_GRP) v[b] = m_pu[(ad - PB) * 8 + b];
    end else if (ad == A_CTRL) v[CTRL_RSEL] = m_rsel;
    return v;
  endfunction

  // ==================== Reference model ====================
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_lat = RST_LATCH;
      m_dir = RST_DIR;
      m_pu = RST_PU;
      m_rsel = RST_CTRL[CTRL_RSEL];
      m_small = 1'b0;
      {e_oe, e_out, e_pu} = '0;
      rd_pend = 1'b0;
      rel_cnt = 0;
    end else begin
      rd_pend = reg_rd;
      if (reg_rd) rd_exp = exp_rd(int'(reg_addr));
      for (i = 0; i < NPIN; i++) begin
        if (bus_mode && i < NBUS_PIN) begin
          e_oe[i] = bus_oe[i];
          e_out[i] = bus_out[i];
          e_pu[i] = 1'b0;
        end else begin
          e_oe[i] = m_dir[i] | periph_oe[i];
          e_out[i] = periph_oe[i] ? periph_out[i] : m_lat[i];
          e_pu[i] = m_pu[i / PU_GRP] & ~m_dir[i] & ~periph_oe[i];
        end
        if (IN_ONLY_MASK[i] || (m_small && SMALL_NC_MASK[i])) begin
          e_oe[i] = 1'b0;
          e_pu[i] = 1'b0;
        end
      end
      if (rel_cnt == 0) m_small = pkg_small;
      if (rel_cnt < 2) rel_cnt++;
      a = int'(reg_addr);
      if (reg_wr) begin
        if (a < NPORT) m_lat[a * 8 +: 8] = reg_wdata;
        else if (a >= DB && a < DB + NPORT)
          m_dir[(a - DB) * 8 +: 8] = reg_wdata & ~IN_ONLY_MASK[(a - DB) * 8 +: 8];
        else if (a >= PB && a < PB + NPU_REG) begin
          for (g = 0; g < 8; g++) if ((a - PB) * 8 + g < NPU_GRP) m_pu[(a - PB) * 8 + g] = reg_wdata[g];
        end else if (a == A_CTRL) m_rsel = reg_wdata[CTRL_RSEL];
      end
    end
  end

  // ==================== Checks ====================
  task automatic chk_pad(string nm, logic [NPIN-1:0] e, logic [NPIN-1:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_rd(logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR reg_rdata expected %h seen %h", e, s);
    end
  endtask
  always @(negedge sys_clk) begin
    if (chk_en) begin
      chk_pad("pad_oe", e_oe, pad_oe);
      chk_pad("pad_pu", e_pu, pad_pu);
      chk_pad("pad_out", e_out & e_oe, pad_out & e_oe);
      chk_rd(rd_pend ? rd_exp : 8'h00, reg_rdata);
    end
  end

  // ==================== Bus tasks ====================
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
  endtask
  task automatic rd(logic [7:0] ad);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ad;
  endtask
  task automatic idle();
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic rd_all();
    for (int k = 0; k < NPORT; k++) rd(8'(k));
    for (int k = 0; k < NPORT; k++) rd(8'(DB + k));
    for (int k = 0; k < NPU_REG; k++) rd(8'(PB + k));
    rd(A_CTRL);
    for (int k = 0; k < 5; k++) rd(bad[k]);
    idle();
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==================== Sequence ====================
  initial begin
    seed = 32'd72409;
    {rst_b, reg_wr, reg_rd, bus_mode, pkg_small, chk_en} = '0;
    {reg_addr, reg_wdata, bus_oe, bus_out, periph_oe, periph_out, ext_val} = '0;
    ext_en = '1;
    failures = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    #30 rst_b = 1'b1;
    chk_en = 1'b1;
    rd_all();
    for (int it = 0; it < 12; it++) begin
      if (it == 6) begin
        #30 rst_b = 1'b0;
        pkg_small = 1'b1;
        repeat (3) @(posedge sys_clk);
        #30 rst_b = 1'b1;
        rd_all();
      end
      periph_oe <= r88() & r88() & r88();
      periph_out <= r88();
      ext_val <= r88();
      bus_mode <= (it % 3 == 2);
      bus_oe <= NBUS_PIN'({rnd(), rnd()});
      bus_out <= NBUS_PIN'({rnd(), rnd()});
      for (int k = 0; k < NPORT; k++) wr(8'(k), 8'(rnd()));
      for (int k = 0; k < NPORT; k++) wr(8'(DB + k), 8'(rnd()));
      for (int k = 0; k < NPU_REG; k++) wr(8'(PB + k), 8'(rnd()));
      wr(A_CTRL, 8'(rnd()));
      for (int k = 0; k < 5; k++) wr(bad[k], 8'(rnd()));
      repeat (3) idle();
      rd_all();
    end
    // Pull-ups alone hold the input pins high, except the externally driven input-only pin and the padless pins
    ext_en <= IN_ONLY_MASK;
    periph_oe <= '0;
    bus_mode <= 1'b0;
    for (int k = 0; k < NPORT; k++) wr(8'(DB + k), 8'h00);
    for (int k = 0; k < NPU_REG; k++) wr(8'(PB + k), 8'hFF);
    repeat (3) idle();
    rd_all();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
